// File: lpsr_cfg.svh
// Constants for the line printer status and reject logic
`ifndef LPSR_CFG_SVH
`define LPSR_CFG_SVH
// Register byte offsets
`define LPSR_OFF_CMD    12'h000
`define LPSR_OFF_STAT   12'h004
`define LPSR_OFF_IRQST  12'h008
`define LPSR_OFF_IRQMSK 12'h00C
`define LPSR_OFF_CTRL   12'h010
`define LPSR_OFF_REJ    12'h014
// Status word layout
`define LPSR_ALARM_WORD 16'h003C
`define LPSR_BIT_READY  0
`define LPSR_BIT_BUSY   1
`define LPSR_BIT_PROT   7
`define LPSR_BIT_TOF    9
`define LPSR_BIT_EIGHT  10
// Command codes (write to command register, low byte)
`define LPSR_CMD_CLEAR  8'h01
`define LPSR_CMD_SPACE1 8'h02
`define LPSR_CMD_SPACE2 8'h03
`define LPSR_CMD_CHAN   8'h04
`define LPSR_CMD_LPI8   8'h05
`define LPSR_CMD_DATA   8'h06
`define LPSR_CMD_PRINT  8'h07
// Interrupt status bits
`define LPSR_IRQ_ALARM  0
`define LPSR_IRQ_REJ    1
`define LPSR_IRQ_DONE   2
// Form geometry and timing
`define LPSR_FORM_LINES 8'd132
`define LPSR_LINE_NS_6  32'd80
`define LPSR_LINE_NS_8  32'd64
`define LPSR_PRINT_NS   32'd400
`define LPSR_CLK_NS     32'd8
`endif

// File: lpsr_cmd_if.sv
// Command path between bus slave and motion engine
`timescale 1ns/1ps
`default_nettype none
interface lpsr_cmd_if;
  lpsr_pkg::lpsr_cmd_t cmd;   // Accepted command pulse
  logic                busy;  // Engine busy
  logic                tof;   // At top of form
  logic                eight; // Eight lines per inch in force
  modport src (output cmd, input busy, tof, eight);
  modport eng (input cmd, output busy, tof, eight);
endinterface
`default_nettype wire

// File: lpsr_host.sv
// Host channel model: single word AHB-Lite transfers and busy waits
`timescale 1ns/1ps
`default_nettype none
module lpsr_host (
  input  wire logic        clk_sys, // System clock
  input  wire logic        hready,  // Bus ready
  input  wire logic [31:0] hrdata,  // Read data
  input  wire logic        busy,    // Printer busy
  output logic             hsel,    // Slave select
  output logic [11:0]      haddr,   // Address
  output logic [1:0]       htrans,  // Transfer type
  output logic             hwrite,  // Write
  output logic [2:0]       hsize,   // Always a word
  output logic [31:0]      hwdata   // Write data
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'b010;
  end
  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // No new motion until busy is gone; busy lags the engine a cycle
  task automatic idle(output int n);
    n = 0;
    @(posedge clk_sys);
    #1;
    while (busy === 1'b1) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// File: lpsr_monitor.sv
// Port checker for the printer status and reject logic
`timescale 1ns/1ps
`default_nettype none
module lpsr_monitor (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        reset,      // Synchronous reset
  input  wire logic        hsel,       // Slave select
  input  wire logic [11:0] haddr,      // Address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic [31:0] hrdata,     // Read data
  input  wire logic        alarmPin,   // Alarm level
  input  wire logic        protectPin, // Protect switch
  input  wire logic        progProt,   // Program protected
  input  wire logic        irq,        // Interrupt
  input  wire logic        busy,       // Busy
  input  wire logic        rejectOut   // Reject flag
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [2:0]  alSt, prSt;        // Cycles each pin has been steady
  logic        alPv, prPv;        // Pin levels one cycle back
  logic        ph, phWr;          // A data phase is under way
  logic [11:0] phAd;              // Its address
  logic        selA, maskA, mskZ; // Shadows of select and mask
  // Pins are taken as settled only after the synchroniser has caught up
  wire aHi = alarmPin && alSt == 3'd7;
  wire aLo = !alarmPin && alSt == 3'd7;
  wire pHi = protectPin && prSt == 3'd7 && !progProt;
  wire uPr = progProt || (!protectPin && prSt == 3'd7);
  wire stRd = hsel && htrans[1] && !hwrite && haddr == 12'h004;
  wire cmdW = ph && phWr && phAd == 12'h000 && aLo && !busy;
  wire rejC = hwdata[7:0] inside {8'h01, 8'h02, 8'h03, 8'h06};
  // Shadow state; a clear loads select from its write data bit 16, even when the clear is rejected
  always_ff @(posedge clk_sys) begin
    alPv <= alarmPin;
    prPv <= protectPin;
    if (reset) begin
      {alSt, prSt, ph, selA, maskA} <= '0;
      mskZ <= 1'b1;
    end else begin
      alSt <= (alarmPin != alPv) ? 3'd0 : alSt + {2'd0, alSt != 3'd7};
      prSt <= (protectPin != prPv) ? 3'd0 : prSt + {2'd0, prSt != 3'd7};
      ph   <= hsel && htrans[1];
      phWr <= hwrite;
      phAd <= haddr;
      if (ph && phWr && phAd == 12'h00C) begin
        maskA <= hwdata[0];
        mskZ  <= hwdata[2:0] == 3'd0;
      end
      if (ph && phWr && phAd == 12'h010)
        selA <= hwdata[0];
      if (ph && phWr && phAd == 12'h000 && hwdata[7:0] == 8'h01)
        selA <= hwdata[16];
    end
  end
  alarm_word_a:
    assert property (stRd && aHi |=> hrdata == 32'h0000_003C)
    else $error("alarm status word wrong");
  alarm_irq_a:
    assert property (aHi && selA && maskA |-> ##[0:3] irq)
    else $error("alarm interrupt missing");
  masked_quiet_a:
    assert property (mskZ && $past(mskZ) && $past(mskZ, 2) |-> !irq)
    else $error("interrupt with mask clear");
  sticky_irq_a:
    assert property (irq && !ph && !$past(ph) |=> irq)
    else $error("interrupt dropped without a write");
  protect_bit_a:
    assert property (stRd && aLo && protectPin && prSt == 3'd7 |=> hrdata[7])
    else $error("protect status bit low");
  reject_flag_a:
    assert property (cmdW && pHi && rejC |-> ##[1:3] rejectOut)
    else $error("protected command not rejected");
  no_motion_a:
    assert property (cmdW && pHi && rejC |=> !busy [*4])
    else $error("rejected command moved paper");
  motion_busy_a:
    assert property (cmdW && uPr && hwdata[7:0] inside {8'h02, 8'h03}
                     |-> ##[1:3] busy ##[1:40] !busy)
    else $error("space busy window wrong");
endmodule
bind lpsr_top lpsr_monitor u_mon (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
  .alarmPin(alarmPin), .protectPin(protectPin), .progProt(progProt),
  .irq(irq), .busy(busy), .rejectOut(rejectOut)
);
`default_nettype wire

// File: lpsr_motion.sv
// Paper motion engine: spacing, channel seek, print, pitch
`timescale 1ns/1ps
`default_nettype none
`include "lpsr_cfg.svh"
module lpsr_motion #(
  parameter int LINES = 132 // Lines per form
) (
  input  wire logic clk_sys,    // System clock
  input  wire logic reset,      // Synchronous reset
  input  wire logic clkEn,      // Clock enable
  input  wire logic alarm,      // Synchronised alarm level
  lpsr_cmd_if.eng   cmdPort     // Command path
);
  localparam int CYC6 = (`LPSR_LINE_NS_6 + `LPSR_CLK_NS - 1) / `LPSR_CLK_NS;
  localparam int CYC8 = (`LPSR_LINE_NS_8 + `LPSR_CLK_NS - 1) / `LPSR_CLK_NS;
  localparam int CYCP = (`LPSR_PRINT_NS + `LPSR_CLK_NS - 1) / `LPSR_CLK_NS;
  typedef struct packed {
    lpsr_pkg::lpsr_state_t state;  // Engine state
    logic [7:0]            line;   // Line on form, 0 = top
    logic [1:0]            left;   // Lines still to move
    logic [3:0]            chan;   // Channel being sought
    logic [7:0]            slew;   // Lines slewed in this seek
    logic [7:0]            tmr;    // Cycle timer
    logic                  eight;  // Pitch select
  } lpsr_mot_t;
  lpsr_mot_t st;
  lpsr_mot_t next_st;
  logic [7:0] lineNext; // Following line with wrap
  logic       punched;  // Format tape punch at lineNext
  // Format tape: ch1 top, ch12 last line, ch2..6 and 7..11 every k lines
  function automatic logic tapeHole(input logic [3:0] ch,
                                    input logic [7:0] ln);
    logic [7:0] k;
    k = 8'd0;
    if (ch == 4'd1) begin
      tapeHole = (ln == 8'd0);
    end else if (ch == 4'd12) begin
      tapeHole = (ln == 8'(LINES - 1));
    end else begin
      k = (ch <= 4'd6) ? 8'(ch - 4'd1) : 8'(ch - 4'd6);
      tapeHole = (ln != 8'd0) && ((ln % k) == 8'd0);
    end
  endfunction
  always_comb begin
    lineNext = (st.line == 8'(LINES - 1)) ? 8'd0 : 8'(st.line + 8'd1);
    punched  = tapeHole(st.chan, lineNext);
  end
  // Engine sequencing
  always_comb begin
    next_st = st;
    case (st.state)
      lpsr_pkg::LPSR_IDLE: begin
        if (cmdPort.cmd.valid && !alarm) begin
          next_st.tmr = 8'd0;
          case (cmdPort.cmd.code)
            `LPSR_CMD_CLEAR: begin
              next_st.eight = 1'b0;
            end
            `LPSR_CMD_LPI8: begin
              next_st.eight = 1'b1;
            end
            `LPSR_CMD_SPACE1: begin
              next_st.left  = 2'd1;
              next_st.state = lpsr_pkg::LPSR_MOVE;
            end
            `LPSR_CMD_SPACE2: begin
              next_st.left  = 2'd2;
              next_st.state = lpsr_pkg::LPSR_MOVE;
            end
            `LPSR_CMD_CHAN: begin
              next_st.chan  = cmdPort.cmd.chan;
              next_st.slew  = 8'd0;
              next_st.state = lpsr_pkg::LPSR_SEEK;
            end
            `LPSR_CMD_PRINT: begin
              next_st.state = lpsr_pkg::LPSR_PRINT;
            end
            default: begin
              next_st.state = st.state;
            end
          endcase
        end
      end
      lpsr_pkg::LPSR_MOVE: begin
        // One line per line time at the chosen pitch
        next_st.tmr = 8'(st.tmr + 8'd1);
        if (st.tmr == 8'((st.eight ? CYC8 : CYC6) - 1)) begin
          next_st.tmr  = 8'd0;
          next_st.line = lineNext;
          next_st.left = 2'(st.left - 2'd1);
          if (st.left == 2'd1) begin
            next_st.state = lpsr_pkg::LPSR_IDLE;
          end
        end
      end
      lpsr_pkg::LPSR_SEEK: begin
        // Slew until the next punch in the chosen channel
        // A channel with no punch on this form would slew forever;
        // stopping after one whole form keeps busy from sticking
        next_st.tmr = 8'(st.tmr + 8'd1);
        if (st.tmr == 8'((st.eight ? CYC8 : CYC6) - 1)) begin
          next_st.tmr  = 8'd0;
          next_st.line = lineNext;
          next_st.slew = 8'(st.slew + 8'd1);
          if (punched || st.slew == 8'(LINES - 1)) begin
            next_st.state = lpsr_pkg::LPSR_IDLE;
          end
        end
      end
      lpsr_pkg::LPSR_PRINT: begin
        next_st.tmr = 8'(st.tmr + 8'd1);
        if (st.tmr == 8'(CYCP - 1)) begin
          next_st.state = lpsr_pkg::LPSR_IDLE;
        end
      end
      default: begin
        next_st.state = lpsr_pkg::LPSR_IDLE;
      end
    endcase
    // A clear also abandons motion in progress
    if (cmdPort.cmd.valid && !alarm &&
        cmdPort.cmd.code == `LPSR_CMD_CLEAR) begin
      next_st.state = lpsr_pkg::LPSR_IDLE;
      next_st.eight = 1'b0;
    end
  end
  // Engine state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st       <= '0;
      st.state <= lpsr_pkg::LPSR_IDLE;
    end else if (clkEn) begin
      st <= next_st;
    end
  end
  assign cmdPort.busy  = (st.state != lpsr_pkg::LPSR_IDLE);
  assign cmdPort.tof   = (st.line == 8'd0);
  assign cmdPort.eight = st.eight;
endmodule
`default_nettype wire

// File: lpsr_pkg.sv
// Types shared by the line printer status and reject logic
package lpsr_pkg;
  typedef enum logic [2:0] {
    LPSR_IDLE  = 3'b000,
    LPSR_MOVE  = 3'b001,
    LPSR_SEEK  = 3'b010,
    LPSR_PRINT = 3'b011
  } lpsr_state_t;
  typedef struct packed {
    logic [7:0]  code;
    logic [3:0]  chan;
    logic        valid;
  } lpsr_cmd_t;
endpackage

// File: lpsr_sync.sv
// Two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module lpsr_sync (
  input  wire logic clk_sys,  // System clock
  input  wire logic reset,    // Synchronous reset
  input  wire logic clkEn,    // Clock enable
  input  wire logic pinIn,    // Asynchronous pin
  output logic      levelOut  // Synchronised level
);
  typedef struct packed {
    logic meta; // First stage, read only by second
    logic hold; // Second stage
  } lpsr_sync_t;
  lpsr_sync_t st;
  lpsr_sync_t next_st;
  // Shift the pin through both stages
  always_comb begin
    next_st      = st;
    next_st.meta = pinIn;
    next_st.hold = st.meta;
  end
  // Register the stages
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end
  assign levelOut = st.hold;
endmodule
`default_nettype wire

// File: lpsr_top.sv
// Line printer status, interrupt and command reject logic on AHB-Lite
// Summary of operation
// - Alarm present: status reads 003C exactly
// - Enabled, unmasked alarm raises interrupt
// - Alarm persists until operator clears it
// - Protect switch shows in status bit 7
// - Protected: reject clear, space, data output
// - After channel 1 eject, bit 9 set
// - Bit 9 clear three spaces, set fourth
// - Select command sets eight lines per inch
// - Clear restores default six lines per inch
// - Channels 1 to 12 advance to punch
// - Single and double space commands
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lpsr_cfg.svh"
module lpsr_top #(
  parameter int LINES = 132 // Lines per form
) (
  input  wire logic        clk_sys,    // System clock, 125 MHz
  input  wire logic        reset,      // Synchronous reset, high
  input  wire logic        clkEn,      // Clock enable, freezes state
  input  wire logic        hsel,       // AHB slave select
  input  wire logic [11:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hready,     // AHB bus ready
  output logic [31:0]      hrdata,     // AHB read data
  output logic             hreadyout,  // AHB slave ready
  output logic             hresp,      // AHB response, always OKAY
  input  wire logic        alarmPin,   // Printer alarm level, async
  input  wire logic        protectPin, // Printer protect switch, async
  input  wire logic        progProt,   // Issuing program is protected
  output logic             irq,        // Level interrupt
  output logic             busy,       // Printer busy
  output logic             rejectOut   // Last command rejected
);
  typedef struct packed {
    logic        dPhase;  // Data phase pending
    logic        dWrite;  // Pending is a write
    logic [11:0] dAddr;   // Pending address
    logic [31:0] rdata;   // Read data register
    logic [2:0]  irqSt;   // Sticky interrupt status
    logic [2:0]  irqMsk;  // Interrupt mask
    logic        alarmEn; // Alarm interrupt selected
    logic        rej;     // Last command rejected
    logic        busyQ;   // Busy copy for edge and output
    logic        irqQ;    // Registered interrupt
  } lpsr_top_t;
  lpsr_top_t st;
  lpsr_top_t next_st;
  lpsr_cmd_if cmdBus ();
  logic       alarm;     // Synchronised alarm
  logic       protect;   // Synchronised protect
  logic [2:0] irqEvt;    // Events: alarm level, reject and done pulses
  logic [15:0] statWord; // Assembled status word
  logic [7:0] wCode;     // Command code being written
  logic       guarded;   // Command subject to protection
  logic       doReject;  // Command refused
  // Pin synchronisers
  lpsr_sync uSyncAlarm (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .pinIn    (alarmPin),
    .levelOut (alarm)
  );
  lpsr_sync uSyncProt (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .pinIn    (protectPin),
    .levelOut (protect)
  );
  lpsr_motion #(
    .LINES (LINES)
  ) uMotion (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .alarm   (alarm),
    .cmdPort (cmdBus.eng)
  );
  // Status word; an alarm overrides everything with one fixed pattern
  always_comb begin
    statWord = 16'h0000;
    if (alarm) begin
      statWord = `LPSR_ALARM_WORD;
    end else begin
      statWord[`LPSR_BIT_READY] = 1'b1;
      statWord[`LPSR_BIT_BUSY]  = cmdBus.busy;
      statWord[`LPSR_BIT_PROT]  = protect;
      statWord[`LPSR_BIT_TOF]   = cmdBus.tof;
      statWord[`LPSR_BIT_EIGHT] = cmdBus.eight;
    end
  end
  // Command decode from the pending write data
  always_comb begin
    wCode   = hwdata[7:0];
    guarded = (wCode == `LPSR_CMD_CLEAR) || (wCode == `LPSR_CMD_SPACE1) ||
              (wCode == `LPSR_CMD_SPACE2) || (wCode == `LPSR_CMD_DATA);
    doReject = st.dPhase && st.dWrite && (st.dAddr == `LPSR_OFF_CMD) &&
               protect && !progProt && guarded;
  end
  // Motion commands only when idle and not refused; busy ones drop
  always_comb begin
    cmdBus.cmd.code  = wCode;
    cmdBus.cmd.chan  = hwdata[11:8];
    cmdBus.cmd.valid = st.dPhase && st.dWrite &&
                       (st.dAddr == `LPSR_OFF_CMD) && !doReject &&
                       hwdata[11:8] <= 4'd12;
  end
  // Events: alarm level, reject, end of motion
  always_comb begin
    irqEvt                  = 3'b000;
    irqEvt[`LPSR_IRQ_ALARM] = alarm && st.alarmEn;
    irqEvt[`LPSR_IRQ_REJ]   = doReject;
    irqEvt[`LPSR_IRQ_DONE]  = st.busyQ && !cmdBus.busy;
  end
  // Bus slave and register file
  always_comb begin
    next_st       = st;
    next_st.busyQ = cmdBus.busy;
    next_st.irqSt = st.irqSt | irqEvt;
    if (st.dPhase && st.dWrite) begin
      if (st.dAddr == `LPSR_OFF_CMD) begin
        next_st.rej = doReject;
        if (!doReject && wCode == `LPSR_CMD_CLEAR) begin
          next_st.alarmEn = hwdata[16];
        end
      end else if (st.dAddr == `LPSR_OFF_IRQST) begin
        // Write one clears; a new event the same cycle wins
        next_st.irqSt = (st.irqSt & ~hwdata[2:0]) | irqEvt;
      end else if (st.dAddr == `LPSR_OFF_IRQMSK) begin
        next_st.irqMsk = hwdata[2:0];
      end else if (st.dAddr == `LPSR_OFF_CTRL) begin
        next_st.alarmEn = hwdata[0];
      end
    end
    next_st.dPhase = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_st.dPhase = 1'b1;
      next_st.dWrite = hwrite;
      next_st.dAddr  = haddr;
      if (haddr == `LPSR_OFF_STAT) begin
        next_st.rdata = {16'h0000, statWord};
      end else if (haddr == `LPSR_OFF_IRQST) begin
        next_st.rdata = {29'd0, st.irqSt};
      end else if (haddr == `LPSR_OFF_IRQMSK) begin
        next_st.rdata = {29'd0, st.irqMsk};
      end else if (haddr == `LPSR_OFF_CTRL) begin
        next_st.rdata = {31'd0, st.alarmEn};
      end else if (haddr == `LPSR_OFF_REJ) begin
        next_st.rdata = {31'd0, st.rej};
      end else begin
        next_st.rdata = 32'h0000_0000;                    // Unmapped reads zero
      end
    end
    next_st.irqQ = |(next_st.irqSt & next_st.irqMsk);
  end
  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end
  assign hrdata    = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = st.irqQ;
  assign busy      = st.busyQ;
  assign rejectOut = st.rej;
endmodule
`default_nettype wire

// File: tb_lpsr_top.sv
// Self-checking bench for the printer status and reject logic
`timescale 1ns/1ps
`default_nettype none
`include "lpsr_cfg.svh"
module tb_lpsr_top;
  logic        clk_sys = 0, reset = 1, clkEn = 1; // Clock, reset, enable
  logic        alarmPin = 0, protectPin = 0;    // Printer pins
  logic        progProt = 0, pp, eight;         // Program protection
  logic        hsel, hwrite, irq, busy, rejectOut, hresp;
  wire logic   hready;                          // Slave ready fed back
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [7:0]  c;
  logic [7:0]  tbl [3] = '{8'h02, 8'h03, 8'h05};  // Random command pool
  logic [7:0]  rej [4] = '{8'h01, 8'h02, 8'h03, 8'h06};
  int          n_errors = 0, num_checks = 0, cyc = 0, n, e;
  integer      seed = 32'h0000_cc2d;
  always #4 clk_sys = ~clk_sys;
  lpsr_top #(.LINES(4)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .alarmPin(alarmPin),
    .protectPin(protectPin), .progProt(progProt), .irq(irq),
    .busy(busy), .rejectOut(rejectOut));
  lpsr_host u_host (
    .clk_sys(clk_sys), .hready(hready), .hrdata(hrdata), .busy(busy),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [11:0] a);
    u_host.xfer(a, 1'b0, 32'h0000_0000, q);
  endtask
  // Command then wait for the motion to end, counting busy cycles
  task automatic go(input logic [31:0] d);
    wr(12'h000, d);
    u_host.idle(n);
  endtask
  // Busy cycles of one space command at the pitch in force
  function automatic int lenOf(input logic [7:0] k, input logic e8);
    return (k == 8'h03 ? 2 : 1) *
      ((e8 ? `LPSR_LINE_NS_8 : `LPSR_LINE_NS_6) / `LPSR_CLK_NS);
  endfunction
  // A hang is cut short well beyond the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize;
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 0;
    rd(12'h004);
    chk("status", 32'h0000_0001, q & 32'h0000_0403);
    chk("okay", 32'h0000_0002, {30'd0, hready, hresp});
    go(32'h0000_0002);
    chk("space1", lenOf(8'h02, 0), n);
    go(32'h0000_0003);
    chk("space2", lenOf(8'h03, 0), n);
    go(32'h0000_0005);
    rd(12'h004);
    chk("eight", 1, q[10]);
    go(32'h0000_0003);
    chk("space8", lenOf(8'h03, 1), n);
    go(32'h0000_0001);
    go(32'h0000_0002);
    chk("space6", lenOf(8'h02, 0), n);
    go(32'h0000_0007);
    chk("print", `LPSR_PRINT_NS / `LPSR_CLK_NS, n);
    go(32'h0000_0D04);
    chk("chan13", 0, n);
    // Freezing the clock enable mid-space must hold busy high
    wr(12'h000, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    clkEn <= 0;
    repeat (20) @(posedge clk_sys);
    chk("freeze", 1, busy);
    clkEn <= 1;
    u_host.idle(n);
    $display("test spacing done");
    // Every tape channel; top and last line have known marks
    for (int k = 1; k <= 12; k++) begin
      go({20'h0_0000, 4'(k), 8'h04});
      rd(12'h004);
      if (k == 1 || k == 12)
        chk("tof", k == 1, q[9]);
    end
    go(32'h0000_0104);
    for (int i = 1; i <= 4; i++) begin
      go(32'h0000_0002);
      rd(12'h004);
      chk("tof", i == 4, q[9]);
    end
    $display("test tape done");
    protectPin <= 1;
    repeat (10) @(posedge clk_sys);
    rd(12'h004);
    chk("protect", 1, q[7]);
    foreach (rej[i]) begin
      go({24'h00_0000, rej[i]});
      chk("motion", 0, n);
      rd(12'h014);
      chk("reject", 1, q[0]);
      chk("rejectOut", 1, rejectOut);
    end
    rd(12'h008);
    chk("irqrej", 2, q & 32'h0000_0002);
    wr(12'h008, 32'h0000_0002);
    rd(12'h008);
    chk("irqrej", 0, q & 32'h0000_0002);
    eight = 0;
    // Random mix of spaces and pitch with random program protection
    repeat (16) begin
      pp = 1'($random(seed));
      c = tbl[$unsigned($random(seed)) % 3];
      progProt <= pp;
      go({24'h00_0000, c});
      e = (c == 8'h05 || !pp) ? 0 : lenOf(c, eight);
      chk("random", e, n);
      if (c == 8'h05)
        eight = 1;
    end
    $display("test protect done");
    protectPin <= 0;
    progProt <= 0;
    wr(12'h010, 32'h0000_0001);
    wr(12'h00C, 32'h0000_0001);
    alarmPin <= 1;
    repeat (10) @(posedge clk_sys);
    chk("irq", 1, irq);
    repeat (3) begin
      rd(12'h004);
      chk("alarmword", 32'h0000_003C, q);
    end
    wr(12'h008, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    chk("irq", 1, irq);
    go(32'h0000_0002);
    chk("blocked", 0, n);
    wr(12'h00C, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    chk("irq", 0, irq);
    alarmPin <= 0;
    repeat (10) @(posedge clk_sys);
    wr(12'h008, 32'h0000_0001);
    wr(12'h00C, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    chk("irq", 0, irq);
    $display("test alarm done");
    summarize;
  end
endmodule
`default_nettype wire
